//--- shared/cafi_consts.vh
// cafi_consts.vh: offsets, field positions and reset values of the
// acceptance-filter stage. Definitions only; include by bare name.
`ifndef CAFI_CONSTS_VH
`define CAFI_CONSTS_VH

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define CAFI_OFS_LIST_MODE   12'h000
`define CAFI_OFS_WIDE_SCALE  12'h004
`define CAFI_OFS_QUEUE_SEL   12'h008
`define CAFI_OFS_ACTIVE      12'h00C
`define CAFI_OFS_Q0_STATUS   12'h010
`define CAFI_OFS_Q1_STATUS   12'h014
`define CAFI_OFS_BANK_BASE   12'h040
`define CAFI_BANK_STRIDE     12'h008

// ****************************************************************
// queue status fields
// ****************************************************************
`define CAFI_ST_INDEX_MSB    7
`define CAFI_ST_PENDING_BIT  8

// ****************************************************************
// 32-bit scale layout: std[31:21] ext[20:3] format[2] type[1]
// 16-bit scale layout: std[15:5] type[4] format[3] ext17_15[2:0]
// ****************************************************************
`define CAFI_W32_USED        32'hFFFF_FFFE
`define CAFI_H16_ALL         16'hFFFF

// ****************************************************************
// reset values and bus answers
// ****************************************************************
`define CAFI_RST_WORD        32'h0000_0000
`define CAFI_RESP_OKAY       2'h0
`define CAFI_RESP_SLVERR     2'h2

`endif

//--- design/cafi_filter.v
// cafi_filter.v: acceptance-filter stage of a CAN receive path, with
// its filter banks and configuration behind an AXI4-Lite slave.
// Assumes the protocol receiver presents one identifier per pulse of
// rx_valid, synchronous to aclk, and the queues sit downstream.
//
// Behaviour
// RQ1: there are 28 banks, each steered to queue zero or queue one.
// RQ2: a frame accepted by a bank goes to the queue of that bank.
// RQ3: only an activated bank can accept; software keeps unused ones off.
// RQ4: every accepted frame carries the number of its accepting filter.
// RQ5: that number shows in the queue status register for software.
// RQ6: numbering is per queue and counts inactive banks too.
// RQ7: numbers run up from zero by bank; a bank has 1, 2, 2 or 4 filters.
// RQ8: a 32-bit scale hit beats a 16-bit scale hit.
// RQ9: at equal scale a list hit beats a mask hit.
// RQ10: at equal scale and mode the lowest number wins.
// RQ11: mask filters compare only bits whose mask bit is set.
// RQ12: list filters need an exact identifier match.
// RQ13: 32-bit filters see std, ext, format and type; 16-bit see std,
//   type, format and ext bits 17 to 15.
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`include "cafi_consts.vh"
`default_nettype none

module cafi_filter #(
  parameter NUM_BANKS = 28,
  parameter IDX_W     = 8
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rx_valid,
  input  wire [10:0] rx_standard_identifier,
  input  wire [17:0] rx_extended_identifier,
  input  wire        rx_frame_format_bit,
  input  wire        rx_frame_type_bit,
  output reg         acc_valid,
  output reg         acc_queue,
  output reg  [IDX_W-1:0] acc_matched_filter_number,
  output reg         acc_reject
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function hit16;
    input [15:0] frame;
    input [15:0] id;
    input [15:0] mask;
    begin
      hit16 = ((frame ^ id) & mask) == 16'h0000; // RQ11 RQ12
    end
  endfunction

  function hit32;
    input [31:0] frame;
    input [31:0] id;
    input [31:0] mask;
    begin
      hit32 = ((frame ^ id) & mask & `CAFI_W32_USED) == 32'h0000_0000;
    end
  endfunction

  // bank number of an address, or NUM_BANKS when it is no bank word
  function [5:0] bank_of;
    input [11:0] addr;
    reg   [11:0] rel;
    begin
      rel = addr - `CAFI_OFS_BANK_BASE;
      if (addr < `CAFI_OFS_BANK_BASE || rel[11:3] >= NUM_BANKS ||
          addr[1:0] != 2'b00) begin
        bank_of = NUM_BANKS[5:0];
      end else begin
        bank_of = rel[8:3];
      end
    end
  endfunction

  function [31:0] strobe;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  be;
    integer k;
    begin
      strobe = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          strobe[k*8 +: 8] = val[k*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************************************
  // configuration state
  // ****************************************************************
  reg [NUM_BANKS-1:0] list_mode_r;
  reg [NUM_BANKS-1:0] wide_scale_r;
  reg [NUM_BANKS-1:0] queue_sel_r;
  reg [NUM_BANKS-1:0] active_r;
  reg [31:0]          fd0_r [0:NUM_BANKS-1];
  reg [31:0]          fd1_r [0:NUM_BANKS-1];
  reg [IDX_W-1:0]     q0_index_r;
  reg [IDX_W-1:0]     q1_index_r;
  reg                 q0_pending_r;
  reg                 q1_pending_r;

  // ****************************************************************
  // frame words and winner search
  // ****************************************************************
  wire [31:0] frame32 = {rx_standard_identifier, rx_extended_identifier,
                         rx_frame_format_bit, rx_frame_type_bit,
                         1'b0}; // RQ13
  wire [15:0] frame16 = {rx_standard_identifier, rx_frame_type_bit,
                         rx_frame_format_bit,
                         rx_extended_identifier[17:15]}; // RQ13

  reg [IDX_W-1:0] run0;
  reg [IDX_W-1:0] run1;
  reg [IDX_W-1:0] base;
  reg [IDX_W-1:0] span;
  reg [IDX_W-1:0] off;
  reg             bhit;
  reg [1:0]       rank;
  reg             best_hit;
  reg [1:0]       best_rank;
  reg             best_queue;
  reg [IDX_W-1:0] best_index;
  reg [31:0]      w0;
  reg [31:0]      w1;
  integer         b;

  always @* begin
    run0 = {IDX_W{1'b0}};
    run1 = {IDX_W{1'b0}};
    base = {IDX_W{1'b0}};
    span = {IDX_W{1'b0}};
    off = {IDX_W{1'b0}};
    bhit = 1'b0;
    rank = 2'b00;
    best_hit = 1'b0;
    best_rank = 2'b00;
    best_queue = 1'b0;
    best_index = {IDX_W{1'b0}};
    w0 = 32'h0000_0000;
    w1 = 32'h0000_0000;
    for (b = 0; b < NUM_BANKS; b = b + 1) begin
      w0 = fd0_r[b];
      w1 = fd1_r[b];
      base = queue_sel_r[b] ? run1 : run0; // RQ6
      rank = {wide_scale_r[b], list_mode_r[b]}; // RQ8 RQ9
      bhit = 1'b0;
      off = {IDX_W{1'b0}};
      case (rank)
        2'b11: begin
          span = 8'd2;
          if (hit32(frame32, w0, 32'hFFFF_FFFF)) begin
            bhit = 1'b1;
          end else if (hit32(frame32, w1, 32'hFFFF_FFFF)) begin
            bhit = 1'b1;
            off = 8'd1;
          end
        end
        2'b10: begin
          span = 8'd1;
          bhit = hit32(frame32, w0, w1);
        end
        2'b01: begin
          span = 8'd4;
          if (hit16(frame16, w0[15:0], `CAFI_H16_ALL)) begin
            bhit = 1'b1;
          end else if (hit16(frame16, w0[31:16], `CAFI_H16_ALL)) begin
            bhit = 1'b1;
            off = 8'd1;
          end else if (hit16(frame16, w1[15:0], `CAFI_H16_ALL)) begin
            bhit = 1'b1;
            off = 8'd2;
          end else if (hit16(frame16, w1[31:16], `CAFI_H16_ALL)) begin
            bhit = 1'b1;
            off = 8'd3;
          end
        end
        default: begin
          span = 8'd2;
          if (hit16(frame16, w0[15:0], w0[31:16])) begin
            bhit = 1'b1;
          end else if (hit16(frame16, w1[15:0], w1[31:16])) begin
            bhit = 1'b1;
            off = 8'd1;
          end
        end
      endcase // RQ7
      // ascending scan with strict compare keeps the lowest number
      if (bhit && active_r[b] &&
          (!best_hit || rank > best_rank)) begin // RQ3 RQ10
        best_hit = 1'b1;
        best_rank = rank;
        best_queue = queue_sel_r[b]; // RQ2
        best_index = base + off; // RQ4
      end
      if (queue_sel_r[b]) begin
        run1 = run1 + span;
      end else begin
        run0 = run0 + span;
      end
    end
  end

  // ****************************************************************
  // bus handshakes
  // ****************************************************************
  // address and data are taken together, one write at a time
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rd_take = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;

  // control words widened to a bus word, merged, then cut back to banks
  wire [31:0] list_mode_wr  = strobe({{(32-NUM_BANKS){1'b0}}, list_mode_r},
                                     s_axi_wdata, s_axi_wstrb);
  wire [31:0] wide_scale_wr = strobe({{(32-NUM_BANKS){1'b0}}, wide_scale_r},
                                     s_axi_wdata, s_axi_wstrb);
  wire [31:0] queue_sel_wr  = strobe({{(32-NUM_BANKS){1'b0}}, queue_sel_r},
                                     s_axi_wdata, s_axi_wstrb);
  wire [31:0] active_wr     = strobe({{(32-NUM_BANKS){1'b0}}, active_r},
                                     s_axi_wdata, s_axi_wstrb);
  wire [5:0] wr_bank = bank_of(s_axi_awaddr);
  wire [5:0] rd_bank = bank_of(s_axi_araddr);
  wire       wr_clr0 = wr_take && s_axi_awaddr == `CAFI_OFS_Q0_STATUS &&
                       s_axi_wstrb[1] && s_axi_wdata[`CAFI_ST_PENDING_BIT];
  wire       wr_clr1 = wr_take && s_axi_awaddr == `CAFI_OFS_Q1_STATUS &&
                       s_axi_wstrb[1] && s_axi_wdata[`CAFI_ST_PENDING_BIT];
  wire       set0 = rx_valid && best_hit && !best_queue;
  wire       set1 = rx_valid && best_hit && best_queue;
  reg        wr_ok;
  reg [31:0] rd_word;
  reg        rd_ok;

  always @* begin
    wr_ok = 1'b1;
    case (s_axi_awaddr)
      `CAFI_OFS_LIST_MODE, `CAFI_OFS_WIDE_SCALE, `CAFI_OFS_QUEUE_SEL,
      `CAFI_OFS_ACTIVE, `CAFI_OFS_Q0_STATUS, `CAFI_OFS_Q1_STATUS: begin
        wr_ok = 1'b1;
      end
      default: begin
        wr_ok = wr_bank != NUM_BANKS[5:0];
      end
    endcase
  end

  always @* begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `CAFI_OFS_LIST_MODE:  rd_word[NUM_BANKS-1:0] = list_mode_r;
      `CAFI_OFS_WIDE_SCALE: rd_word[NUM_BANKS-1:0] = wide_scale_r;
      `CAFI_OFS_QUEUE_SEL:  rd_word[NUM_BANKS-1:0] = queue_sel_r;
      `CAFI_OFS_ACTIVE:     rd_word[NUM_BANKS-1:0] = active_r;
      `CAFI_OFS_Q0_STATUS: begin
        rd_word[`CAFI_ST_INDEX_MSB:0] = q0_index_r; // RQ5
        rd_word[`CAFI_ST_PENDING_BIT] = q0_pending_r;
      end
      `CAFI_OFS_Q1_STATUS: begin
        rd_word[`CAFI_ST_INDEX_MSB:0] = q1_index_r; // RQ5
        rd_word[`CAFI_ST_PENDING_BIT] = q1_pending_r;
      end
      default: begin
        rd_ok = rd_bank != NUM_BANKS[5:0];
        if (rd_ok) begin
          rd_word = s_axi_araddr[2] ? fd1_r[rd_bank[4:0]]
                                    : fd0_r[rd_bank[4:0]];
        end
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      list_mode_r <= {NUM_BANKS{1'b0}};
      wide_scale_r <= {NUM_BANKS{1'b0}};
      queue_sel_r <= {NUM_BANKS{1'b0}};
      active_r <= {NUM_BANKS{1'b0}};
      for (i = 0; i < NUM_BANKS; i = i + 1) begin
        fd0_r[i] <= `CAFI_RST_WORD;
        fd1_r[i] <= `CAFI_RST_WORD;
      end
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CAFI_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CAFI_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `CAFI_RESP_OKAY : `CAFI_RESP_SLVERR;
        case (s_axi_awaddr)
          `CAFI_OFS_LIST_MODE: list_mode_r <=
            list_mode_wr[NUM_BANKS-1:0];
          `CAFI_OFS_WIDE_SCALE: wide_scale_r <=
            wide_scale_wr[NUM_BANKS-1:0];
          `CAFI_OFS_QUEUE_SEL: queue_sel_r <=
            queue_sel_wr[NUM_BANKS-1:0]; // RQ1
          `CAFI_OFS_ACTIVE: active_r <=
            active_wr[NUM_BANKS-1:0]; // RQ3
          default: begin
            if (wr_ok && wr_bank != NUM_BANKS[5:0]) begin
              if (s_axi_awaddr[2]) begin
                fd1_r[wr_bank[4:0]] <= strobe(fd1_r[wr_bank[4:0]],
                  s_axi_wdata, s_axi_wstrb);
              end else begin
                fd0_r[wr_bank[4:0]] <= strobe(fd0_r[wr_bank[4:0]],
                  s_axi_wdata, s_axi_wstrb);
              end
            end
          end
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `CAFI_RESP_OKAY : `CAFI_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // acceptance result and queue status; a new frame wins over a clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_valid <= 1'b0;
      acc_reject <= 1'b0;
      acc_queue <= 1'b0;
      acc_matched_filter_number <= {IDX_W{1'b0}};
      q0_index_r <= {IDX_W{1'b0}};
      q1_index_r <= {IDX_W{1'b0}};
      q0_pending_r <= 1'b0;
      q1_pending_r <= 1'b0;
    end else begin
      acc_valid <= rx_valid && best_hit;
      acc_reject <= rx_valid && !best_hit;
      if (rx_valid && best_hit) begin
        acc_queue <= best_queue; // RQ2
        acc_matched_filter_number <= best_index; // RQ4
      end
      if (set0) begin
        q0_index_r <= best_index; // RQ5
        q0_pending_r <= 1'b1;
      end else if (wr_clr0) begin
        q0_pending_r <= 1'b0;
      end
      if (set1) begin
        q1_index_r <= best_index; // RQ5
        q1_pending_r <= 1'b1;
      end else if (wr_clr1) begin
        q1_pending_r <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

//--- bench/cafi_checker.sv
// cafi_checker.sv: timing checks on the filter stage ports.
// Assumes one clock, aclk, and a synchronous active-low reset.
`default_nettype none
module cafi_checker #(
  parameter IDX_W = 8
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             rx_valid,
  input wire logic             acc_valid,
  input wire logic             acc_reject,
  input wire logic             acc_queue,
  input wire logic [IDX_W-1:0] acc_matched_filter_number
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // checks
  // ********
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_acc_answer: assert property (rx_valid |=> acc_valid != acc_reject)
    else $error("frame got no single answer");
  a_acc_quiet: assert property (
    !rx_valid |=> !acc_valid && !acc_reject)
    else $error("answer without a frame");
  // guarded by past reset so a one-edge reset cannot trip it
  a_idx_hold: assert property (
    $past(aresetn) && !acc_valid
      |-> $stable({acc_queue, acc_matched_filter_number}))
    else $error("filter number moved without acceptance");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata) && s_axi_rvalid)
    else $error("read answer dropped early");
endmodule
bind cafi_filter cafi_checker #(.IDX_W(IDX_W)) u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rx_valid,
  .acc_valid, .acc_reject, .acc_queue, .acc_matched_filter_number);
`default_nettype wire

//--- bench/cafi_rx_model.sv
// cafi_rx_model.sv: protocol receiver handing identifiers onward.
// Assumes the caller runs send from a process clocked by aclk.
`default_nettype none
module cafi_rx_model (
  input  wire logic  aclk,
  output logic       rx_valid,
  output logic [10:0] rx_standard_identifier,
  output logic [17:0] rx_extended_identifier,
  output logic       rx_frame_format_bit,
  output logic       rx_frame_type_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid = 1'b0;
    rx_standard_identifier = 11'h000;
    rx_extended_identifier = 18'h00000;
    rx_frame_format_bit = 1'b0;
    rx_frame_type_bit = 1'b0;
  end
  // one pulse per frame; fields invert after it so no stale match
  task automatic send(input logic [10:0] s, input logic [17:0] e,
                      input logic f, input logic t);
    @(posedge aclk);
    rx_valid <= 1'b1;
    {rx_standard_identifier, rx_extended_identifier} <= {s, e};
    {rx_frame_format_bit, rx_frame_type_bit} <= {f, t};
    @(posedge aclk);
    rx_valid <= 1'b0;
    {rx_standard_identifier, rx_extended_identifier} <= ~{s, e};
    {rx_frame_format_bit, rx_frame_type_bit} <= ~{f, t};
  endtask
endmodule
`default_nettype wire

//--- bench/can_acceptance_filter_index_test.sv
// can_acceptance_filter_index_test.sv: self-checking bench.
// Assumes the filter stage, its bound checker and the rx model.
`include "cafi_consts.vh"
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
`define WAITFOR(c) \
  for (n = 0; n < 200; n++) begin \
    @(posedge aclk); \
    if (c) break; \
  end \
  if (!(c)) hang();
module can_acceptance_filter_index_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = `CAFI_RESP_OKAY;
  localparam logic [1:0] SE = `CAFI_RESP_SLVERR;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, rx_valid;
  logic        rx_frame_format_bit, rx_frame_type_bit, acc_valid;
  logic        acc_queue, acc_reject;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [10:0] rx_standard_identifier;
  logic [17:0] rx_extended_identifier;
  logic [7:0]  acc_matched_filter_number;
  int          n_fail, n_compared;
  cafi_filter dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid,
    .rx_standard_identifier, .rx_extended_identifier,
    .rx_frame_format_bit, .rx_frame_type_bit, .acc_valid, .acc_queue,
    .acc_matched_filter_number, .acc_reject);
  cafi_rx_model rxm (.aclk, .rx_valid, .rx_standard_identifier,
    .rx_extended_identifier, .rx_frame_format_bit, .rx_frame_type_bit);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ********
  // tasks
  // ********
  task automatic results();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    $display("[ERR] %0t wait ran out", $time);
    results();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    `WAITFOR(s_axi_awready && s_axi_wready)
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    s_axi_bready <= 1'b1;
    `WAITFOR(s_axi_bvalid)
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, r)
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    `WAITFOR(s_axi_arready)
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    `WAITFOR(s_axi_rvalid)
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, d)
    `CHK(s_axi_rresp, r)
  endtask
  // frame in, then the one-cycle answer is looked at once it settles
  task automatic fr(input logic [10:0] s, input logic [17:0] e,
                    input logic f, t, a, q, input logic [7:0] i);
    rxm.send(s, e, f, t);
    #1;
    `CHK(acc_valid, a)
    `CHK(acc_reject, !a)
    if (a) begin
      `CHK(acc_queue, q)
      `CHK(acc_matched_filter_number, i)
    end
  endtask
  // ********
  // sequence
  // ********
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = '0;
    {n_fail, n_compared} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CAFI_OFS_LIST_MODE, 32'h0, OK);
    rd(`CAFI_OFS_Q1_STATUS, 32'h0, OK);
    wr(`CAFI_OFS_LIST_MODE, 32'h0000_000A, 4'hF, OK);
    wr(`CAFI_OFS_WIDE_SCALE, 32'h0800_0009, 4'hF, OK);
    wr(`CAFI_OFS_QUEUE_SEL, 32'h0800_000C, 4'hF, OK);
    wr(`CAFI_OFS_ACTIVE, 32'h0800_000B, 4'hF, OK);
    wr(12'h040, 32'h2460_0000, 4'hF, OK);
    wr(12'h044, 32'hFFE0_0000, 4'hF, OK);
    wr(12'h048, 32'h4020_4000, 4'hF, OK);
    wr(12'h04C, 32'h4060_4040, 4'hF, OK);
    wr(12'h050, 32'hFFE0_8000, 4'hF, OK);
    wr(12'h054, 32'hFFE0_8020, 4'hF, OK);
    wr(12'h058, 32'h6009_1A2C, 4'hF, OK);
    wr(12'h05C, 32'h6020_000A, 4'hF, OK);
    wr(12'h118, 32'hFFE0_0000, 4'hF, OK);
    wr(12'h11C, 32'hFFE0_0000, 4'hF, OK);
    wr(12'h120, 32'h1234_5678, 4'hF, SE);
    rd(12'h11C, 32'hFFE0_0000, OK);
    rd(12'h042, 32'h0, SE);
    rd(`CAFI_OFS_WIDE_SCALE, 32'h0800_0009, OK);
    fr(11'h123, 18'h3FFFF, 1, 1, 1, 0, 8'h00);
    fr(11'h122, 18'h00000, 0, 0, 0, 0, 8'h00);
    fr(11'h202, 18'h07FFF, 0, 0, 1, 0, 8'h03);
    fr(11'h203, 18'h08000, 0, 0, 0, 0, 8'h00);
    fr(11'h201, 18'h00000, 0, 1, 0, 0, 8'h00);
    fr(11'h301, 18'h00001, 0, 1, 1, 1, 8'h03);
    fr(11'h300, 18'h12344, 1, 0, 0, 0, 8'h00);
    fr(11'h300, 18'h12345, 1, 0, 1, 1, 8'h02);
    fr(11'h400, 18'h00000, 0, 0, 0, 0, 8'h00);
    fr(11'h7FF, 18'h00000, 0, 0, 1, 1, 8'h04);
    rd(`CAFI_OFS_Q0_STATUS, 32'h0000_0103, OK);
    rd(`CAFI_OFS_Q1_STATUS, 32'h0000_0104, OK);
    wr(`CAFI_OFS_Q0_STATUS, 32'h0000_0100, 4'h2, OK);
    rd(`CAFI_OFS_Q0_STATUS, 32'h0000_0003, OK);
    wr(`CAFI_OFS_ACTIVE, 32'h0800_000F, 4'hF, OK);
    fr(11'h401, 18'h00000, 0, 0, 1, 1, 8'h01);
    wr(`CAFI_OFS_ACTIVE, 32'h0800_001F, 4'hF, OK);
    fr(11'h555, 18'h00000, 0, 0, 1, 0, 8'h05);
    fr(11'h123, 18'h00000, 0, 0, 1, 0, 8'h00);
    fr(11'h202, 18'h00000, 0, 0, 1, 0, 8'h03);
    fr(11'h7FF, 18'h00000, 0, 0, 1, 1, 8'h04);
    results();
  end
endmodule
`default_nettype wire
